// ---- logic/bpi_map.vh ----
// Constants for the burst pseudo-static memory pin interface.
// How it works
// [RQ1] Controller gives a refresh opportunity within every 4 us of select low.
// [RQ2] Opportunity is a clocked select deassert or select high over 15 ns.
// [RQ3] Select may stay low between bursts; new burst accepted within limit.
// [RQ4] Refresh collision on variable read stretches wait up to twice latency.
// [RQ5] Controller suspends a read burst by holding burst clock without rises.
// [RQ6] Suspended read with output strobe low keeps last word on all lines.
// [RQ7] At row end with wrap off controller deasserts select within 2 or 3 clocks.
// [RQ8] Burst writes assert wait for exactly latency-code cycles in both modes; code 0 gives one cycle here.
// [RQ9] Latency code comes from configuration bits 13 to 11.
// [RQ10] Variable latency code 2 without collision gives four-clock first data.
// [RQ11] Fixed latency delay equals code plus one clock.
// [RQ12] Controller meets address setup only if select setup exceeds 20 ns.
// [RQ13] Controller waits at least 150 us in deep sleep before exiting.
// [RQ14] Leaving deep sleep needs select held low at least 10 us.
// [RQ15] Device initialises within 150 us; controller waits before accessing.
// [RQ16] Write strobe low at burst start marks a write burst.
// [RQ17] Controller deasserts select between async and variable-latency bursts.
// [RQ18] In synchronous mode controller holds select high 5 ns between async cycles.
// [RQ19] Controller counts select low time and forces deassertion before 4 us.
`ifndef BPI_MAP_VH
`define BPI_MAP_VH

// Configuration field positions.
`define BPI_CFG_LAT_MSB     13
`define BPI_CFG_LAT_LSB     11
`define BPI_CFG_VAR_LAT     14
`define BPI_CFG_WAIT_POL    10
`define BPI_CFG_WAIT_EARLY  8
`define BPI_CFG_WRAP_OFF    3

// Timing figures in nanoseconds and the reference clock period.
`define BPI_REF_CLK_NS      10
`define BPI_T_SEL_MAX_NS    4000
`define BPI_T_SLEEP_MIN_NS  150000
`define BPI_T_WAKE_MIN_NS   10000
`define BPI_T_INIT_MAX_NS   150000

`endif

// ---- logic/bpi_fifo2.v ----
// Two-entry buffer with valid and ready on both sides.
module bpi_fifo2 #(
	parameter WIDTH = 16
) (
	// Clock and reset.
	input  wire             i_ref_clk,
	input  wire             i_rstn,
	input  wire             i_clear,
	// Filling side.
	input  wire             i_valid,
	output wire             o_ready,
	input  wire [WIDTH-1:0] i_data,
	// Draining side.
	output wire             o_valid,
	input  wire             i_ready,
	output wire [WIDTH-1:0] o_data
);
	reg [WIDTH-1:0] head_reg;
	reg [WIDTH-1:0] tail_reg;
	reg [1:0]       count_reg;
	wire            push;
	wire            pop;

	// Full at two words, so the source sees back-pressure honestly.
	assign o_ready = (count_reg != 2'h2);
	assign o_valid = (count_reg != 2'h0);
	assign o_data  = head_reg;
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	// Head always holds the oldest word; the tail only backs it up.
	always @(posedge i_ref_clk) begin
		if (!i_rstn || i_clear) begin
			count_reg <= 2'h0;
			head_reg  <= {WIDTH{1'b0}};
			tail_reg  <= {WIDTH{1'b0}};
		end else if (push && !pop) begin
			if (count_reg == 2'h0)
				head_reg <= i_data;
			else
				tail_reg <= i_data;
			count_reg <= count_reg + 2'h1;
		end else if (pop && !push) begin
			head_reg  <= tail_reg;
			count_reg <= count_reg - 2'h1;
		end else if (pop && push) begin
			if (count_reg == 2'h1) begin
				head_reg <= i_data;
			end else begin
				head_reg <= tail_reg;
				tail_reg <= i_data;
			end
		end
	end
endmodule

// ---- logic/bpi_burst_if.v ----
// Device-side burst read and write engine behind the memory pins.
`include "bpi_map.vh"
module bpi_burst_if #(
	parameter ADDR_W   = 22,
	parameter DATA_W   = 16,
	parameter ROW_W    = 7,
	parameter TIMER_W  = 24,
	parameter INIT_CYC = `BPI_T_INIT_MAX_NS / `BPI_REF_CLK_NS,
	parameter SLEEP_CYC =
		(`BPI_T_SLEEP_MIN_NS + `BPI_REF_CLK_NS - 1) / `BPI_REF_CLK_NS
) (
	// Clock and reset.
	input  wire              i_ref_clk,
	input  wire              i_rstn,
	// Memory pins driven by the controller.
	input  wire              i_burst_clk,
	input  wire              i_select_n,
	input  wire              i_addr_latch_n,
	input  wire              i_write_n,
	input  wire              i_output_n,
	input  wire [ADDR_W-1:0] i_addr,
	// Two-way data lines and the wait pin.
	input  wire [DATA_W-1:0] i_dq,
	output wire [DATA_W-1:0] o_dq,
	output wire              o_dq_oe,
	output wire              o_wait,
	output wire              o_wait_oe,
	// Configuration and status.
	input  wire [15:0]       i_bus_config,
	input  wire              i_refresh_busy,
	input  wire              i_deep_sleep_req,
	output wire              o_init_done,
	output wire              o_deep_sleep,
	output wire              o_select_overrun,
	output wire              o_refresh_window,
	// Read stream from the core array.
	output wire              o_core_rd_start,
	output wire [ADDR_W-1:0] o_core_rd_addr,
	input  wire              i_core_rd_valid,
	output wire              o_core_rd_ready,
	input  wire [DATA_W-1:0] i_core_rd_data,
	// Write stream to the core array.
	output wire              o_core_wr_valid,
	input  wire              i_core_wr_ready,
	output wire [ADDR_W-1:0] o_core_wr_addr,
	output wire [DATA_W-1:0] o_core_wr_data
);
	localparam SW = 5 + ADDR_W + DATA_W;
	localparam [TIMER_W-1:0] SEL_MAX_CYC =
		`BPI_T_SEL_MAX_NS / `BPI_REF_CLK_NS;
	localparam [TIMER_W-1:0] WAKE_CYC =
		(`BPI_T_WAKE_MIN_NS + `BPI_REF_CLK_NS - 1) / `BPI_REF_CLK_NS;
	localparam [TIMER_W-1:0] INIT_LIM  = INIT_CYC;
	localparam [TIMER_W-1:0] SLEEP_LIM = SLEEP_CYC;
	localparam [2:0] ST_INIT   = 3'h0;
	localparam [2:0] ST_IDLE   = 3'h1;
	localparam [2:0] ST_LAT    = 3'h2;
	localparam [2:0] ST_DATA   = 3'h3;
	localparam [2:0] ST_ROWEND = 3'h4;
	localparam [2:0] ST_SLEEP  = 3'h5;

	reg  [SW-1:0]      sync1_reg;
	reg  [SW-1:0]      sync2_reg;
	reg  [SW-1:0]      sync3_reg;
	reg  [SW-1:0]      filt_reg;
	reg                clk_prev_reg;
	reg  [2:0]         state_reg;
	reg  [2:0]         state_next;
	reg  [4:0]         cnt_reg;
	reg  [4:0]         cnt_next;
	reg                write_reg;
	reg                write_next;
	reg  [ADDR_W-1:0]  addr_reg;
	reg  [ADDR_W-1:0]  addr_next;
	reg  [ADDR_W-1:0]  start_addr_reg;
	reg                rd_start_reg;
	reg  [DATA_W-1:0]  dq_out_reg;
	reg                dq_valid_reg;
	reg  [TIMER_W-1:0] timer_reg;
	reg  [TIMER_W-1:0] sel_cnt_reg;
	reg                overrun_reg;
	reg                rd_pop;
	reg                wr_push;

	wire               f_clk;
	wire               f_sel_n;
	wire               f_latch_n;
	wire               f_write_n;
	wire               f_out_n;
	wire [ADDR_W-1:0]  f_addr;
	wire [DATA_W-1:0]  f_dq;
	wire               rise;
	wire               sel;
	wire               start;
	wire [2:0]         lat_code;
	wire               var_lat;
	wire [4:0]         rd_delay;
	wire [4:0]         rd_load;
	wire [4:0]         wr_load;
	wire               row_last;
	wire               rd_valid;
	wire [DATA_W-1:0]  rd_data;
	wire               wr_ready;
	wire               wait_act;

	assign {f_clk, f_sel_n, f_latch_n, f_write_n, f_out_n, f_addr, f_dq} =
		filt_reg;

	// Pins pass three flops; a bit changes once stages two and three agree.
	always @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			sync1_reg    <= {SW{1'b0}};
			sync2_reg    <= {SW{1'b0}};
			sync3_reg    <= {SW{1'b0}};
			filt_reg     <= {SW{1'b0}};
			clk_prev_reg <= 1'b0;
		end else begin
			sync1_reg    <= {i_burst_clk, i_select_n, i_addr_latch_n,
				i_write_n, i_output_n, i_addr, i_dq};
			sync2_reg    <= sync1_reg;
			sync3_reg    <= sync2_reg;
			filt_reg     <= (sync2_reg & sync3_reg) |
				(filt_reg & (sync2_reg | sync3_reg));
			clk_prev_reg <= f_clk;
		end
	end

	assign rise     = f_clk & ~clk_prev_reg;
	assign sel      = ~f_sel_n;
	assign lat_code = i_bus_config[`BPI_CFG_LAT_MSB:`BPI_CFG_LAT_LSB]; // see [RQ9]
	assign var_lat  = i_bus_config[`BPI_CFG_VAR_LAT];

	// Variable code 2 gives four clocks; fixed gives code plus one.
	assign rd_delay = var_lat ? {2'b00, lat_code} + 5'h02 // see [RQ10]
		: {2'b00, lat_code} + 5'h01; // see [RQ11]
	// A pending refresh doubles the variable read latency.
	assign rd_load = (var_lat && i_refresh_busy) ?
		{rd_delay[3:0], 1'b0} - 5'h01 : rd_delay - 5'h01; // see [RQ4]
	// Writes hold wait for the bare code (one clock for code 0), whatever the mode.
	assign wr_load = (lat_code == 3'h0) ? 5'h01 : {2'b00, lat_code}; // see [RQ8]

	// A new latch strobe with select low restarts the burst at once.
	assign start = rise & sel & ~f_latch_n &
		(state_reg != ST_INIT) & (state_reg != ST_SLEEP); // see [RQ3]
	assign row_last = i_bus_config[`BPI_CFG_WRAP_OFF] &
		(&addr_reg[ROW_W-1:0]);

	// Burst sequencing; latency countdown and data steps are paced by burst clock rises.
	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		write_next = write_reg;
		addr_next  = addr_reg;
		rd_pop     = 1'b0;
		wr_push    = 1'b0;
		case (state_reg)
		ST_INIT: begin
			if (timer_reg >= INIT_LIM) // see [RQ15]
				state_next = ST_IDLE;
		end
		ST_SLEEP: begin
			if (timer_reg >= SLEEP_LIM && sel_cnt_reg >= WAKE_CYC)
				state_next = ST_INIT; // see [RQ13] [RQ14]
		end
		ST_IDLE: begin
			if (i_deep_sleep_req && !sel)
				state_next = ST_SLEEP;
		end
		ST_LAT: begin
			if (rise && cnt_reg <= 5'h01) begin
				state_next = ST_DATA;
				rd_pop     = ~write_reg & rd_valid;
			end else if (rise) begin
				cnt_next = cnt_reg - 5'h01;
			end
		end
		ST_DATA: begin
			if (rise) begin
				rd_pop  = ~write_reg & rd_valid;
				wr_push = write_reg & wr_ready;
				if (rd_pop || wr_push) begin
					addr_next = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
					if (row_last)
						state_next = ST_ROWEND;
				end
			end
		end
		ST_ROWEND: begin
			state_next = ST_ROWEND;
		end
		default: begin
			state_next = ST_IDLE;
		end
		endcase
		// Select high ends any burst; a latch strobe starts a new one.
		if (!sel && state_reg >= ST_LAT && state_reg <= ST_ROWEND)
			state_next = ST_IDLE;
		if (start) begin
			state_next = ST_LAT;
			write_next = ~f_write_n; // see [RQ16]
			addr_next  = f_addr;
			cnt_next   = f_write_n ? rd_load : wr_load;
			rd_pop     = 1'b0;
			wr_push    = 1'b0;
		end
	end

	// State, counters and the held output word.
	always @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			state_reg      <= ST_INIT;
			cnt_reg        <= 5'h00;
			write_reg      <= 1'b0;
			addr_reg       <= {ADDR_W{1'b0}};
			start_addr_reg <= {ADDR_W{1'b0}};
			rd_start_reg   <= 1'b0;
			dq_out_reg     <= {DATA_W{1'b0}};
			dq_valid_reg   <= 1'b0;
			timer_reg      <= {TIMER_W{1'b0}};
			sel_cnt_reg    <= {TIMER_W{1'b0}};
			overrun_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			write_reg    <= write_next;
			addr_reg     <= addr_next;
			rd_start_reg <= start & f_write_n;
			if (start)
				start_addr_reg <= f_addr;
			// A stopped clock pops nothing, so the last word stays driven.
			if (rd_pop) begin
				dq_out_reg   <= rd_data; // see [RQ6]
				dq_valid_reg <= 1'b1;
			end else if (start || !sel) begin
				dq_valid_reg <= 1'b0;
			end
			// One timer serves both power-up and deep sleep residency.
			if (state_next != state_reg)
				timer_reg <= {TIMER_W{1'b0}};
			else if (timer_reg != {TIMER_W{1'b1}})
				timer_reg <= timer_reg + {{(TIMER_W-1){1'b0}}, 1'b1};
			// Select-low time, saturating so a stuck select cannot wrap.
			if (!sel)
				sel_cnt_reg <= {TIMER_W{1'b0}};
			else if (sel_cnt_reg != {TIMER_W{1'b1}})
				sel_cnt_reg <= sel_cnt_reg + {{(TIMER_W-1){1'b0}}, 1'b1};
			// Flags a controller that starved refresh; clears on select high.
			if (!sel)
				overrun_reg <= 1'b0;
			else if (sel_cnt_reg >= SEL_MAX_CYC && state_reg != ST_SLEEP)
				overrun_reg <= 1'b1; // see [RQ1] [RQ19]
		end
	end

	// Read words prefetched from the core; a restart flushes stale ones.
	// The flush also covers the cycle after the start, because the core
	// may still hand over one word of the old stream before it sees the
	// start pulse.
	bpi_fifo2 #(
		.WIDTH (DATA_W)
	) u_rd_buf (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_clear   (start | rd_start_reg),
		.i_valid   (i_core_rd_valid),
		.o_ready   (o_core_rd_ready),
		.i_data    (i_core_rd_data),
		.o_valid   (rd_valid),
		.i_ready   (rd_pop),
		.o_data    (rd_data)
	);

	// Written words wait here if the core stalls; wait then holds the bus.
	bpi_fifo2 #(
		.WIDTH (ADDR_W + DATA_W)
	) u_wr_buf (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_clear   (1'b0),
		.i_valid   (wr_push),
		.o_ready   (wr_ready),
		.i_data    ({addr_reg, f_dq}),
		.o_valid   (o_core_wr_valid),
		.i_ready   (i_core_wr_ready),
		.o_data    ({o_core_wr_addr, o_core_wr_data})
	);

	// Wait covers latency, row end and any buffer stall; the early option
	// releases it one clock ahead of first data.
	assign wait_act = (state_reg == ST_LAT &&
			!(i_bus_config[`BPI_CFG_WAIT_EARLY] && cnt_reg <= 5'h01)) ||
		(state_reg == ST_ROWEND) || // see [RQ7]
		(state_reg == ST_DATA && !write_reg && !rd_valid) ||
		(state_reg == ST_DATA && write_reg && !wr_ready);
	assign o_wait    = wait_act ^ ~i_bus_config[`BPI_CFG_WAIT_POL];
	assign o_wait_oe = sel & (state_reg != ST_SLEEP) &
		(state_reg != ST_INIT);
	assign o_dq      = dq_out_reg;
	assign o_dq_oe   = sel & ~f_out_n & ~write_reg & dq_valid_reg &
		((state_reg == ST_DATA) || (state_reg == ST_ROWEND));

	// Status and core-side request outputs.
	assign o_init_done      = (state_reg != ST_INIT);
	assign o_deep_sleep     = (state_reg == ST_SLEEP);
	assign o_select_overrun = overrun_reg;
	assign o_refresh_window = ~sel; // see [RQ2]
	assign o_core_rd_start  = rd_start_reg;
	assign o_core_rd_addr   = start_addr_reg;
endmodule

// ---- dv/bpi_burst_if_checker.sv ----
// Concurrent checks on the ports of the burst pin engine.
module bpi_burst_if_checker #(
	parameter INIT_CYC = 50
) (
	// Clock, reset and pins.
	input wire        i_ref_clk,
	input wire        i_rstn,
	input wire        i_burst_clk,
	input wire        i_select_n,
	input wire        i_output_n,
	input wire [15:0] i_bus_config,
	input wire        i_core_wr_ready,
	// Outputs under watch.
	input wire [15:0] o_dq,
	input wire        o_dq_oe,
	input wire        o_wait,
	input wire        o_wait_oe,
	input wire        o_init_done,
	input wire        o_deep_sleep,
	input wire        o_select_overrun,
	input wire        o_core_rd_start,
	input wire        o_core_wr_valid,
	input wire [21:0] o_core_wr_addr,
	input wire [15:0] o_core_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	int   up_cnt = 0;
	int   low_cnt = 0;
	int   still_cnt = 0;
	logic clk_q = 1'b0;
	// Time since reset, select low time and time since the last clock pin edge.
	always @(posedge i_ref_clk) begin
		up_cnt <= i_rstn ? up_cnt + 1 : 0;
		low_cnt <= i_select_n ? 0 : low_cnt + 1;
		still_cnt <= (i_burst_clk != clk_q) ? 0 : still_cnt + 1;
		clk_q <= i_burst_clk;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	chk_reset_quiet: assert property (disable iff (1'b0) !i_rstn |=>
		!o_dq_oe && !o_wait_oe && !o_init_done && !o_core_wr_valid)
		else $error("outputs active after a reset edge");
	chk_init_early: assert property (o_init_done |-> up_cnt >= INIT_CYC - 1)
		else $error("ready before the start-up interval");
	chk_init_late: assert property (up_cnt == INIT_CYC + 3 |-> o_init_done)
		else $error("start-up interval overrun");
	chk_wr_hold: assert property (o_core_wr_valid && !i_core_wr_ready |=>
		o_core_wr_valid && $stable(o_core_wr_data) && $stable(o_core_wr_addr))
		else $error("write word changed while stalled");
	chk_rd_pulse: assert property (o_core_rd_start |=> !o_core_rd_start)
		else $error("read start longer than one cycle");
	chk_rd_wait: assert property (o_core_rd_start |->
		##1 (o_wait == i_bus_config[10]) [*5])
		else $error("wait not shown during read latency");
	chk_wait_idle: assert property (i_select_n [*8] |-> !o_wait_oe)
		else $error("wait driven while deselected");
	chk_dq_quiet: assert property (i_output_n [*8] |-> !o_dq_oe)
		else $error("data driven with output strobe high");
	chk_dq_hold: assert property (still_cnt > 6 && o_dq_oe |-> $stable(o_dq))
		else $error("data changed during suspend");
	// Select low is how deep sleep is left, so it is not an overrun there.
	chk_overrun_set: assert property (low_cnt == 420 && !o_deep_sleep |->
		o_select_overrun)
		else $error("long select low not flagged");
	chk_overrun_clr: assert property (i_select_n [*8] |-> !o_select_overrun)
		else $error("overrun flag kept after select high");
endmodule

// ---- dv/bpi_ctrl_model.sv ----
// Behavioural memory controller driving the burst pins.
module bpi_ctrl_model (
	// Reference clock and device data.
	input  wire         i_ref_clk,
	input  wire  [15:0] i_dq,
	input  wire         i_dq_oe,
	// Pins towards the device.
	output logic        o_burst_clk,
	output logic        o_select_n,
	output logic        o_addr_latch_n,
	output logic        o_write_n,
	output logic        o_output_n,
	output logic [21:0] o_addr,
	output logic [15:0] o_dq,
	output logic        o_dq_oe,
	// Read words captured by the controller.
	output logic        o_rd_seen,
	output logic [15:0] o_rd_word
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins start idle: select high, strobes high, clock low.
	initial begin
		{o_burst_clk, o_select_n, o_addr_latch_n, o_write_n} = 4'h7;
		{o_output_n, o_dq_oe, o_rd_seen} = 3'h4;
		{o_addr, o_dq, o_rd_word} = 54'h0;
	end
	// Half a burst clock period is four reference cycles, so the pins
	// set up 40 ns before each rise.
	task automatic half(input logic lvl);
		@(posedge i_ref_clk);
		o_rd_seen <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		o_burst_clk <= lvl;
	endtask
	// Select level held for a number of cycles; the high gap exceeds 15 ns.
	task automatic sel(input logic lvl, input int cyc);
		o_select_n <= lvl;
		repeat (cyc) @(posedge i_ref_clk);
	endtask
	// One burst; the clock stays static outside it and while suspended.
	task automatic burst(input logic wr, input logic [21:0] a, input int lat,
		input int n, input logic [15:0] d, input int hold, input int keep);
		int r;
		o_select_n <= 1'b0;
		o_addr_latch_n <= 1'b0;
		o_write_n <= !wr;
		o_output_n <= wr;
		o_dq_oe <= wr;
		o_addr <= a;
		half(1'b1);
		for (r = 1; r <= lat + n - !wr; r++) begin
			half(1'b0);
			o_addr_latch_n <= 1'b1;
			o_addr <= ~a;
			o_dq <= (r > lat) ? d + r - lat - 1 : ~o_dq;
			if (hold && r == lat + 2)
				repeat (40) @(posedge i_ref_clk);
			half(1'b1);
			if (!wr && r >= lat) begin
				o_rd_word <= i_dq_oe ? i_dq : ~i_dq;
				o_rd_seen <= 1'b1;
			end
		end
		half(1'b0);
		o_dq_oe <= 1'b0;
		o_write_n <= 1'b1;
		o_output_n <= 1'b1;
		if (!keep)
			sel(1'b1, 8);
	endtask
endmodule

// ---- dv/bpi_burst_if_bench.sv ----
// Self-checking bench for the burst pin engine.
module bpi_burst_if_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_ref_clk, i_rstn, i_refresh_busy, i_deep_sleep_req, stall;
	logic        i_core_rd_valid, i_core_wr_ready;
	logic [15:0] i_bus_config;
	logic [21:0] rd_ptr;
	wire         i_burst_clk, i_select_n, i_addr_latch_n, i_write_n;
	wire         i_output_n, o_dq_oe, m_oe, rd_seen, o_wait, o_wait_oe;
	wire         o_init_done, o_deep_sleep, o_select_overrun, o_refresh_window;
	wire         o_core_rd_start, o_core_rd_ready, o_core_wr_valid;
	wire  [21:0] i_addr, o_core_rd_addr, o_core_wr_addr;
	wire  [15:0] o_dq, m_dq, rd_word, o_core_wr_data;
	wire  [15:0] i_core_rd_data = rd_ptr[15:0] ^ 16'ha5c3;
	wire  [15:0] i_dq = m_oe ? m_dq : (o_dq_oe ? o_dq : {16{i_ref_clk}});
	int          seed = 32'h1999_beca;
	int          fail_count, checks_done, v, c;
	logic [15:0] rq[$];
	logic [37:0] wq[$];

	bpi_burst_if #(.INIT_CYC(50), .SLEEP_CYC(50)) u_dut (.i_ref_clk, .i_rstn,
		.i_burst_clk, .i_select_n, .i_addr_latch_n, .i_write_n, .i_output_n,
		.i_addr, .i_dq, .o_dq, .o_dq_oe, .o_wait, .o_wait_oe, .i_bus_config,
		.i_refresh_busy, .i_deep_sleep_req, .o_init_done, .o_deep_sleep,
		.o_select_overrun, .o_refresh_window, .o_core_rd_start,
		.o_core_rd_addr, .i_core_rd_valid, .o_core_rd_ready, .i_core_rd_data,
		.o_core_wr_valid, .i_core_wr_ready, .o_core_wr_addr, .o_core_wr_data);
	bpi_ctrl_model u_ctl (.i_ref_clk, .o_burst_clk(i_burst_clk),
		.o_select_n(i_select_n), .o_addr_latch_n(i_addr_latch_n),
		.o_write_n(i_write_n), .o_output_n(i_output_n), .o_addr(i_addr),
		.o_dq(m_dq), .o_dq_oe(m_oe), .i_dq(o_dq), .i_dq_oe(o_dq_oe),
		.o_rd_seen(rd_seen), .o_rd_word(rd_word));

	function automatic logic [15:0] cfg_of(input int vr, input int cd, input int w);
		return {1'b0, vr[0], cd[2:0], 1'b1, 6'h00, w[0], 3'h0};
	endfunction
	function automatic logic [21:0] addr();
		return $random(seed) & 22'h3f_ff9f;
	endfunction
	task automatic check(input logic [37:0] exp_v, input logic [37:0] got_v);
		checks_done++;
		if (got_v !== exp_v) begin
			fail_count++;
			$display("[ERR] %0t exp %h got %h", $time, exp_v, got_v);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Notes the expected words, then lets the controller run the burst.
	task automatic run(input logic wr, input int lat, input int n, input int hold,
		input int keep, input logic [21:0] a);
		logic [15:0] d;
		int k;
		d = $random(seed);
		for (k = 0; k < n; k++) begin
			if (wr)
				wq.push_back({a + k[21:0], d + k[15:0]});
			else
				rq.push_back((a[15:0] + k) ^ 16'ha5c3);
		end
		u_ctl.burst(wr, a, lat, n, d, hold, keep);
		repeat (8) @(posedge i_ref_clk);
		$display("burst write=%0d latency=%0d done at %0t", wr, lat, $time);
	endtask

	// Reference clock.
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	// Core array: streams words from the requested address, stalls at random.
	always @(posedge i_ref_clk) begin
		if (o_core_rd_start)
			rd_ptr <= o_core_rd_addr;
		else if (i_core_rd_valid && o_core_rd_ready)
			rd_ptr <= rd_ptr + 22'h1;
		if (o_core_rd_start)
			i_core_rd_valid <= 1'b0;
		else if (!i_core_rd_valid || o_core_rd_ready)
			i_core_rd_valid <= ($random(seed) & 3) != 0;
		i_core_wr_ready <= !stall && ($random(seed) % 2 != 0);
	end
	// Compares each finished word with the oldest expectation.
	always @(posedge i_ref_clk) begin
		if (rd_seen)
			check(rq.pop_front(), rd_word);
		if (o_core_wr_valid && i_core_wr_ready)
			check(wq.pop_front(), {o_core_wr_addr, o_core_wr_data});
	end
	// A hung run ends here as a failure.
	initial begin
		repeat (90000) @(posedge i_ref_clk);
		fail_count++;
		test_done();
	end
	// Main sequence.
	initial begin
		{i_rstn, i_refresh_busy, i_deep_sleep_req, stall} = 4'h0;
		{i_core_rd_valid, i_core_wr_ready, rd_ptr} = 24'h0;
		i_bus_config = cfg_of(1, 2, 0);
		repeat (16) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		repeat (30) @(posedge i_ref_clk);
		check(38'h0, o_init_done);
		for (v = 0; v < 200 && o_init_done !== 1'b1; v++) @(posedge i_ref_clk);
		check(38'h1, o_init_done);
		// Latency codes 1 to 6 in both modes, a read then a write.
		for (v = 0; v < 2; v++) begin
			for (c = 1; c < 7; c++) begin
				i_bus_config <= cfg_of(v, c, 0);
				run(0, v ? c + 2 : c + 1, 3, 0, 0, addr());
				run(1, c, 3, 0, 0, addr());
			end
		end
		i_bus_config <= cfg_of(1, 2, 0);
		i_refresh_busy <= 1'b1;
		run(0, 8, 2, 0, 0, addr());
		i_refresh_busy <= 1'b0;
		run(0, 4, 4, 1, 0, addr());
		run(0, 4, 2, 0, 1, addr());
		run(1, 2, 2, 0, 1, addr());
		run(0, 4, 3, 0, 0, addr());
		stall <= 1'b1;
		run(1, 2, 2, 0, 0, addr());
		stall <= 1'b0;
		i_bus_config <= cfg_of(1, 2, 1);
		run(0, 4, 2, 0, 1, 22'h12_347e);
		check(38'h1, o_wait);
		u_ctl.sel(1'b1, 8);
		i_deep_sleep_req <= 1'b1;
		for (v = 0; v < 100 && o_deep_sleep !== 1'b1; v++) @(posedge i_ref_clk);
		check(38'h1, o_deep_sleep);
		i_deep_sleep_req <= 1'b0;
		repeat (60) @(posedge i_ref_clk);
		u_ctl.sel(1'b0, 1010);
		check(38'h1, o_select_overrun);
		check(38'h0, o_init_done);
		u_ctl.sel(1'b1, 8);
		for (v = 0; v < 200 && o_init_done !== 1'b1; v++) @(posedge i_ref_clk);
		check(38'h1, o_init_done);
		$display("deep sleep exit done at %0t", $time);
		check(38'h0, rq.size() + wq.size());
		test_done();
	end
endmodule

bind bpi_burst_if bpi_burst_if_checker #(.INIT_CYC(INIT_CYC)) u_chk (.i_ref_clk,
	.i_rstn, .i_burst_clk, .i_select_n, .i_output_n, .i_bus_config,
	.i_core_wr_ready, .o_dq, .o_dq_oe, .o_wait, .o_wait_oe, .o_init_done,
	.o_deep_sleep,
	.o_select_overrun, .o_core_rd_start, .o_core_wr_valid, .o_core_wr_addr,
	.o_core_wr_data);
